/* File: verilog/subset_pkg.sv */
// Opcodes, register map, field positions and types of the slice
package subset_pkg;
  // Opcode bytes
  localparam logic [7:0] OPC_PREFIX_B = 8'h42;
  localparam logic [7:0] OPC_SET_BIT = 8'h04;
  localparam logic [7:0] OPC_SET_C = 8'h38;
  localparam logic [7:0] OPC_SET_I = 8'h78;
  localparam logic [7:0] OPC_SET_M = 8'hF8;
  localparam logic [7:0] OPC_SET_PS = 8'hE2;
  localparam logic [7:0] OPC_STA_DIR = 8'h85;
  localparam logic [7:0] OPC_STA_DIRX = 8'h95;
  localparam logic [7:0] OPC_HALT_OSC = 8'hDB;
  localparam logic [7:0] OPC_HALT_CLK = 8'hCB;
  localparam logic [7:0] OPC_STX_DIR = 8'h86;
  localparam logic [7:0] OPC_STX_DIRY = 8'h96;
  localparam logic [7:0] OPC_STY_DIR = 8'h84;
  localparam logic [7:0] OPC_STY_DIRX = 8'h94;
  localparam logic [7:0] OPC_A_DPR = 8'h5B;
  localparam logic [7:0] OPC_A_SP = 8'h1B;
  localparam logic [7:0] OPC_A_X = 8'hAA;
  localparam logic [7:0] OPC_A_Y = 8'hA8;
  localparam logic [7:0] OPC_DPR_A = 8'h7B;
  localparam logic [7:0] OPC_SP_A = 8'h3B;
  localparam logic [7:0] OPC_SP_X = 8'hBA;
  localparam logic [7:0] OPC_X_A = 8'h8A;
  localparam logic [7:0] OPC_X_SP = 8'h9A;
  localparam logic [7:0] OPC_X_Y = 8'h9B;
  localparam logic [7:0] OPC_Y_A = 8'h98;
  localparam logic [7:0] OPC_Y_X = 8'hBB;
  localparam logic [7:0] OPC_SWAP_LEAD = 8'h89;
  localparam logic [7:0] OPC_SWAP_TAIL = 8'h28;
  localparam int IDX_MODE_BIT = 4;
  // Cycle counts and byte lengths
  localparam int CYC_W = 4;
  localparam logic [3:0] CYC_IMP = 4'h2;
  localparam logic [3:0] CYC_SET_BIT = 4'h8;
  localparam logic [3:0] CYC_SET_PS = 4'h3;
  localparam logic [3:0] CYC_HALT = 4'h3;
  localparam logic [3:0] CYC_STORE = 4'h4;
  localparam logic [3:0] CYC_SWAP = 4'h6;
  localparam logic [3:0] CYC_PREFIX = 4'h2;
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  // Register file indices
  localparam logic [2:0] REG_A = 3'h0;
  localparam logic [2:0] REG_B = 3'h1;
  localparam logic [2:0] REG_X = 3'h2;
  localparam logic [2:0] REG_Y = 3'h3;
  localparam logic [2:0] REG_SP = 3'h4;
  localparam logic [2:0] REG_DPR = 3'h5;
  localparam int NUM_REGS = 6;
  localparam logic [15:0] REG_RST = 16'h0000;
  // Status byte fields
  localparam int PS_C = 0;
  localparam int PS_I = 2;
  localparam int PS_X = 4;
  localparam int PS_M = 5;
  localparam logic [15:0] PS_RST = 16'h0004;
  // Bus offsets and status word fields
  localparam logic [7:0] OFF_INSN = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_REGS = 8'h08;
  localparam logic [7:0] OFF_PS = 8'h20;
  localparam logic [7:0] OFF_EA = 8'h24;
  localparam logic [7:0] OFF_WAKE = 8'h28;
  localparam int ST_BUSY = 0;
  localparam int ST_OSC = 1;
  localparam int ST_CLK = 2;
  localparam int ST_UNCL = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_LEN_LSB = 8;
  localparam int ST_CYC_LSB = 12;
  typedef enum logic [3:0] {
    op_none, op_move, op_swap, op_store, op_set_bit, op_set_carry,
    op_set_irq, op_set_width, op_set_status, op_halt_osc, op_halt_clk
  } op_type;
  typedef enum logic {st_idle, st_run} state_type;
endpackage

/* File: verilog/opcode_table.sv */
// Opcode table: operation, operands, byte length and cycle count
`timescale 1ns/1ps
module opcode_table (
  input wire logic [7:0] first_i,
  input wire logic [7:0] second_i,
  output subset_pkg::op_type op_o,
  output logic [2:0] src_o,
  output logic [2:0] dst_o,
  output logic [2:0] len_o,
  output logic [3:0] cyc_o
);
  import subset_pkg::*;
  logic pre;
  logic [7:0] opc;

  // A prefix byte shifts the real opcode one place
  assign pre = (first_i == OPC_PREFIX_B);
  assign opc = pre ? second_i : first_i;

  // Classify the opcode, then size it, then apply the prefix
  always_comb begin
    op_o = op_move;
    src_o = REG_A;
    dst_o = REG_A;
    len_o = LEN_1;
    cyc_o = CYC_IMP;
    case (opc)
      OPC_SET_BIT: op_o = op_set_bit;
      OPC_SET_C: op_o = op_set_carry;
      OPC_SET_I: op_o = op_set_irq;
      OPC_SET_M: op_o = op_set_width;
      OPC_SET_PS: op_o = op_set_status;
      OPC_STA_DIR, OPC_STA_DIRX: op_o = op_store;
      OPC_HALT_OSC: op_o = op_halt_osc;
      OPC_HALT_CLK: op_o = op_halt_clk;
      OPC_STX_DIR, OPC_STX_DIRY: begin
        op_o = op_store;
        src_o = REG_X;
      end
      OPC_STY_DIR, OPC_STY_DIRX: begin
        op_o = op_store;
        src_o = REG_Y;
      end
      OPC_A_DPR: {src_o, dst_o} = {REG_A, REG_DPR};
      OPC_A_SP: {src_o, dst_o} = {REG_A, REG_SP};
      OPC_A_X: {src_o, dst_o} = {REG_A, REG_X};
      OPC_A_Y: {src_o, dst_o} = {REG_A, REG_Y};
      OPC_DPR_A: {src_o, dst_o} = {REG_DPR, REG_A};
      OPC_SP_A: {src_o, dst_o} = {REG_SP, REG_A};
      OPC_SP_X: {src_o, dst_o} = {REG_SP, REG_X};
      OPC_X_A: {src_o, dst_o} = {REG_X, REG_A};
      OPC_X_SP: {src_o, dst_o} = {REG_X, REG_SP};
      OPC_X_Y: {src_o, dst_o} = {REG_X, REG_Y};
      OPC_Y_A: {src_o, dst_o} = {REG_Y, REG_A};
      OPC_Y_X: {src_o, dst_o} = {REG_Y, REG_X};
      OPC_SWAP_LEAD: begin
        op_o = (second_i == OPC_SWAP_TAIL) ? op_swap : op_none;
      end
      default: op_o = op_none;
    endcase
    case (op_o)
      op_set_bit: begin
        len_o = LEN_3;
        cyc_o = CYC_SET_BIT;
      end
      op_set_status: begin
        len_o = LEN_2;
        cyc_o = CYC_SET_PS;
      end
      op_store: begin
        len_o = LEN_2;
        cyc_o = CYC_STORE + {3'h0, opc[IDX_MODE_BIT]};
      end
      op_swap: begin
        len_o = LEN_2;
        cyc_o = CYC_SWAP;
      end
      op_halt_osc, op_halt_clk: cyc_o = CYC_HALT;
      default: cyc_o = CYC_IMP;
    endcase
    // Prefix only makes sense where accumulator A takes part
    if (pre) begin
      if ((op_o == op_move && (src_o == REG_A || dst_o == REG_A)) ||
          (op_o == op_store && src_o == REG_A)) begin
        if (src_o == REG_A) src_o = REG_B;
        if (dst_o == REG_A) dst_o = REG_B;
        len_o = len_o + LEN_1;
        cyc_o = cyc_o + CYC_PREFIX;
      end else begin
        op_o = op_none;
      end
    end
  end
endmodule

/* File: verilog/cycle_timer.sv */
// Down counter that paces an instruction over its cycle count
`timescale 1ns/1ps
module cycle_timer #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [W-1:0] count_i,
  output logic done_o
);
  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Reload wins; otherwise count down to zero and stop
  always_comb begin
    cnt_nxt = cnt_r;
    if (load_i) begin
      cnt_nxt = count_i;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Last cycle of the count
  assign done_o = (cnt_r == W'(1));
endmodule

/* File: verilog/subset_core.sv */
// Decode and execute core for the set, store and transfer slice
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////
// Behaviour
// - 04 sets a memory bit, 8 cycles
// - 38 sets carry, 2 cycles
// - 78 sets interrupt disable, 2 cycles
// - F8 sets data length flag, 2 cycles
// - E2 ORs operand into low status byte
// - 85/95 store accumulator, 42 selects B
// - DB stops the oscillator, 3 cycles
// - CB stops core clock only, 3 cycles
// - 86/96 store X, 4/5 cycles
// - 84/94 store Y, 4/5 cycles
// - 5B copies A to page base
// - 42 prefix selects B, adds 2 cycles and 1 byte (4 cycles, 2 bytes on a transfer)
// - 1B copies A to stack pointer
// - AA copies A to X
// - A8 copies A to Y
// - 7B copies page base to A
// - 3B stack to A, BA stack to X
// - 8A copies X to A
// - 9A copies X to stack pointer
// - 9B copies X to Y, 2 cycles
// - 98 Y to A, BB Y to X
// - 89 28 swaps A and B, 6 cycles
module subset_core (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic [15:0] mem_rdata_i,
  output logic mem_rd_o,
  output logic mem_we_o,
  output logic mem_byte_o,
  output logic [23:0] mem_addr_o,
  output logic [15:0] mem_wdata_o,
  input wire logic wake_i,
  output logic osc_stop_o,
  output logic core_halt_o
);
  import subset_pkg::*;

  logic ack_r;
  logic [31:0] dat_r;
  logic bus_req;
  logic wr_hit;
  logic insn_wr;
  logic launch;
  logic retire;
  logic halted;
  state_type state_r;
  op_type dec_op;
  logic [2:0] dec_src;
  logic [2:0] dec_dst;
  logic [2:0] dec_len;
  logic [3:0] dec_cyc;
  op_type ex_op_r;
  logic [2:0] ex_src_r;
  logic [2:0] ex_dst_r;
  logic [7:0] ex_mask_r;
  logic [2:0] ex_len_r;
  logic [3:0] ex_cyc_r;
  logic tmr_done;
  logic [15:0] regs_r [NUM_REGS];
  logic [NUM_REGS-1:0] ret_we;
  logic [15:0] ret_val [NUM_REGS];
  logic [15:0] ps_r;
  logic [23:0] ea_r;
  logic [15:0] rd_data_r;
  logic rd_wait_r;
  logic mem_rd_r;
  logic mem_we_r;
  logic mem_byte_r;
  logic [23:0] mem_addr_r;
  logic [15:0] mem_wdata_r;
  logic wake_s1_r;
  logic wake_s2_r;
  logic osc_stop_r;
  logic core_halt_r;
  logic uncl_r;
  logic refused_r;

  // Apply byte enables to a word
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
      input logic [31:0] new_v, input logic [3:0] sel_v);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel_v[i]) res[8*i +: 8] = new_v[8*i +: 8];
    end
    return res;
  endfunction

  // Narrow registers: flag m for accumulators, x for indexes
  function automatic logic is_narrow(input logic [2:0] r,
      input logic [15:0] ps);
    logic res;
    res = 1'b0;
    if (r == REG_A || r == REG_B) res = ps[PS_M];
    if (r == REG_X || r == REG_Y) res = ps[PS_X];
    return res;
  endfunction

  // Accumulators keep their high byte, indexes clear it when narrow
  function automatic logic [15:0] fit(input logic [2:0] r,
      input logic [15:0] old_v, input logic [15:0] new_v,
      input logic [15:0] ps);
    logic [15:0] res;
    res = new_v;
    if (is_narrow(r, ps)) begin
      if (r == REG_A || r == REG_B) begin
        res = {old_v[15:8], new_v[7:0]};
      end else begin
        res = {8'h00, new_v[7:0]};
      end
    end
    return res;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Bus slave: one wait state, every access acknowledged
  assign bus_req = cyc_i && stb_i && !ack_r;
  assign wr_hit = bus_req && we_i;
  assign insn_wr = wr_hit && (adr_i == OFF_INSN);
  assign halted = osc_stop_r || core_halt_r;
  // Only an idle, running core with a claimed opcode accepts work
  assign launch = insn_wr && (state_r == st_idle) && !halted &&
                  (dec_op != op_none);
  assign retire = (state_r == st_run) && tmr_done;
  assign ack_o = ack_r;
  assign dat_o = dat_r;
  assign mem_rd_o = mem_rd_r;
  assign mem_we_o = mem_we_r;
  assign mem_byte_o = mem_byte_r;
  assign mem_addr_o = mem_addr_r;
  assign mem_wdata_o = mem_wdata_r;
  assign osc_stop_o = osc_stop_r;
  assign core_halt_o = core_halt_r;

  // Ack drops the cycle after it is given
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_req;
    end
  end

  // Read data; unmapped offsets read zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_r <= 32'h0000_0000;
    end else if (bus_req && !we_i) begin
      dat_r <= 32'h0000_0000;
      if (adr_i == OFF_STAT) begin
        dat_r[ST_BUSY] <= (state_r == st_run);
        dat_r[ST_OSC] <= osc_stop_r;
        dat_r[ST_CLK] <= core_halt_r;
        dat_r[ST_UNCL] <= uncl_r;
        dat_r[ST_REFUSED] <= refused_r;
        dat_r[ST_LEN_LSB +: 3] <= ex_len_r;
        dat_r[ST_CYC_LSB +: CYC_W] <= ex_cyc_r;
      end
      if (adr_i == OFF_PS) dat_r[15:0] <= ps_r;
      if (adr_i == OFF_EA) dat_r[23:0] <= ea_r;
      for (int i = 0; i < NUM_REGS; i++) begin
        if (adr_i == OFF_REGS + 8'(4 * i)) dat_r[15:0] <= regs_r[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Decode the written word: byte 0 first, byte 2 is the bit mask
  opcode_table u_table (
    .first_i(dat_i[7:0]),
    .second_i(dat_i[15:8]),
    .op_o(dec_op),
    .src_o(dec_src),
    .dst_o(dec_dst),
    .len_o(dec_len),
    .cyc_o(dec_cyc)
  );

  cycle_timer #(
    .W(CYC_W)
  ) u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(launch),
    .count_i(dec_cyc),
    .done_o(tmr_done)
  );

  // Two states: the timer alone decides when work ends
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= st_idle;
    end else begin
      case (state_r)
        st_idle: if (launch) state_r <= st_run;
        st_run: if (retire) state_r <= st_idle;
        default: state_r <= st_idle;
      endcase
    end
  end

  // Latch the decoded instruction for the whole run
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ex_op_r <= op_none;
      ex_src_r <= REG_A;
      ex_dst_r <= REG_A;
      ex_mask_r <= 8'h00;
      ex_len_r <= 3'h0;
      ex_cyc_r <= 4'h0;
    end else if (launch) begin
      ex_op_r <= dec_op;
      ex_src_r <= dec_src;
      ex_dst_r <= dec_dst;
      ex_mask_r <= dat_i[23:16];
      ex_len_r <= dec_len;
      ex_cyc_r <= dec_cyc;
    end
  end

  // Outcome of the last instruction word written
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      uncl_r <= 1'b0;
      refused_r <= 1'b0;
    end else if (insn_wr) begin
      refused_r <= (state_r != st_idle) || halted;
      uncl_r <= (dec_op == op_none);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register effects at the last cycle of a run
  always_comb begin
    for (int i = 0; i < NUM_REGS; i++) begin
      ret_we[i] = 1'b0;
      ret_val[i] = regs_r[i];
    end
    if (retire && ex_op_r == op_move) begin
      ret_we[ex_dst_r] = 1'b1;
      ret_val[ex_dst_r] = fit(ex_dst_r, regs_r[ex_dst_r],
                              regs_r[ex_src_r], ps_r);
    end
    // Full-width exchange regardless of the length flags
    if (retire && ex_op_r == op_swap) begin
      ret_we[REG_A] = 1'b1;
      ret_we[REG_B] = 1'b1;
      ret_val[REG_A] = regs_r[REG_B];
      ret_val[REG_B] = regs_r[REG_A];
    end
  end

  // One register per entry; the core wins over a bus write
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        regs_r[g] <= REG_RST;
      end else if (ret_we[g]) begin
        regs_r[g] <= ret_val[g];
      end else if (wr_hit && adr_i == OFF_REGS + 8'(4 * g)) begin
        regs_r[g] <= 16'(lane_merge({16'h0000, regs_r[g]}, dat_i,
                                    sel_i));
      end
    end
  end

  // Status flags: hardware sets win over software writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ps_r <= PS_RST;
    end else if (retire) begin
      case (ex_op_r)
        op_set_carry: ps_r[PS_C] <= 1'b1;
        op_set_irq: ps_r[PS_I] <= 1'b1;
        op_set_width: ps_r[PS_M] <= 1'b1;
        op_set_status: ps_r[7:0] <= ps_r[7:0] | ex_mask_r;
        default: ps_r <= ps_r;
      endcase
    end else if (wr_hit && adr_i == OFF_PS) begin
      ps_r <= 16'(lane_merge({16'h0000, ps_r}, dat_i, sel_i));
    end
  end

  // Effective address comes from outside; no mode arithmetic here
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ea_r <= 24'h00_0000;
    end else if (wr_hit && adr_i == OFF_EA) begin
      ea_r <= 24'(lane_merge({8'h00, ea_r}, dat_i, sel_i));
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Memory port: read early for the bit set, write at the end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_r <= 1'b0;
      mem_we_r <= 1'b0;
      mem_byte_r <= 1'b0;
      mem_addr_r <= 24'h00_0000;
      mem_wdata_r <= 16'h0000;
      rd_wait_r <= 1'b0;
      rd_data_r <= 16'h0000;
    end else begin
      mem_rd_r <= launch && (dec_op == op_set_bit);
      rd_wait_r <= mem_rd_r;
      if (rd_wait_r) rd_data_r <= mem_rdata_i;
      if (launch) mem_addr_r <= ea_r;
      mem_we_r <= retire &&
                  (ex_op_r == op_store || ex_op_r == op_set_bit);
      if (retire && ex_op_r == op_store) begin
        mem_byte_r <= is_narrow(ex_src_r, ps_r);
        mem_wdata_r <= regs_r[ex_src_r];
      end
      if (retire && ex_op_r == op_set_bit) begin
        mem_byte_r <= ps_r[PS_M];
        mem_wdata_r <= rd_data_r | {8'h00, ex_mask_r};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Wake pin crosses in through two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_s1_r <= 1'b0;
      wake_s2_r <= 1'b0;
    end else begin
      wake_s1_r <= wake_i;
      wake_s2_r <= wake_s1_r;
    end
  end

  // Stop flags: a stop at retire beats a wake in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_stop_r <= 1'b0;
      core_halt_r <= 1'b0;
    end else begin
      if (retire && ex_op_r == op_halt_osc) begin
        osc_stop_r <= 1'b1;
      end else if (wake_s2_r || (wr_hit && adr_i == OFF_WAKE)) begin
        osc_stop_r <= 1'b0;
      end
      if (retire && ex_op_r == op_halt_clk) begin
        core_halt_r <= 1'b1;
      end else if (wake_s2_r || (wr_hit && adr_i == OFF_WAKE)) begin
        core_halt_r <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks on the core's own behaviour
  logic [3:0] run_cnt_r;
  always_ff @(posedge clk_i) begin
    if (rst_i || launch) begin
      run_cnt_r <= 4'h1;
    end else if (state_r == st_run) begin
      run_cnt_r <= run_cnt_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence bit_launch_s;
    launch && dec_op == op_set_bit;
  endsequence
  sequence bit_read_s;
    mem_rd_o ##1 !mem_rd_o;
  endsequence

  carry_set_a: assert property (
    retire && ex_op_r == op_set_carry |=> ps_r[PS_C])
    else $error("carry not set");
  irq_set_a: assert property (
    retire && ex_op_r == op_set_irq |=> ps_r[PS_I])
    else $error("irq disable not set");
  width_set_a: assert property (
    retire && ex_op_r == op_set_width |=> ps_r[PS_M])
    else $error("data length flag not set");
  status_or_a: assert property (
    retire && ex_op_r == op_set_status |=>
      (ps_r[7:0] & $past(ex_mask_r)) == $past(ex_mask_r))
    else $error("status bits not set");
  bit_read_a: assert property (
    bit_launch_s |=> bit_read_s ##7 mem_we_o)
    else $error("bit set read or write misplaced");
  osc_halt_a: assert property (
    retire && ex_op_r == op_halt_osc |=> osc_stop_o && !core_halt_o)
    else $error("oscillator not stopped");
  clk_halt_a: assert property (
    retire && ex_op_r == op_halt_clk |=> core_halt_o && !osc_stop_o)
    else $error("core clock stop wrong");
  store_x_a: assert property (
    retire && ex_op_r == op_store && ex_src_r == REG_X |=>
      mem_we_o && mem_wdata_o == $past(regs_r[REG_X]))
    else $error("index X not stored");
  swap_pair_a: assert property (
    retire && ex_op_r == op_swap |=>
      regs_r[REG_A] == $past(regs_r[REG_B]) &&
      regs_r[REG_B] == $past(regs_r[REG_A]))
    else $error("accumulators not swapped");
  run_length_a: assert property (
    retire |-> run_cnt_r == ex_cyc_r)
    else $error("run length differs from cycle count");
  pass_on_a: assert property (
    insn_wr && dec_op == op_none |=>
      uncl_r && ex_op_r == $past(ex_op_r))
    else $error("unclaimed opcode acted on");
endmodule

/* File: tb/mem_model.sv */
// Memory model that answers the core one cycle after a read strobe
`timescale 1ns/1ps
module mem_model (
  input wire logic clk_i,
  input wire logic mem_rd_i,
  input wire logic [23:0] mem_addr_i,
  output logic [15:0] mem_rdata_o
);
  // Data valid only in the cycle after the strobe, flipping otherwise
  always_ff @(posedge clk_i) begin
    if (mem_rd_i) begin
      mem_rdata_o <= mem_addr_i[15:0] ^ 16'h5a5a;
    end else begin
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the set, store and transfer slice
`timescale 1ns/1ps
module tb_top;
  import subset_pkg::*;
  typedef struct packed {logic [31:0] v; logic [31:0] m;} note_type;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wake = 0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000, dat_o;
  logic ack_o, mem_rd_o, mem_we_o, mem_byte_o, osc_stop_o, core_halt_o;
  logic [23:0] mem_addr_o;
  logic [15:0] mem_wdata_o, mem_rdata;
  note_type rdq [$];
  logic [40:0] wrq [$];
  int miscompares = 0, compares = 0;
  // Transfer table: opcode, source, destination
  localparam logic [13:0] TT [12] = '{{OPC_A_DPR, REG_A, REG_DPR},
    {OPC_A_SP, REG_A, REG_SP}, {OPC_A_X, REG_A, REG_X},
    {OPC_A_Y, REG_A, REG_Y}, {OPC_DPR_A, REG_DPR, REG_A},
    {OPC_SP_A, REG_SP, REG_A}, {OPC_SP_X, REG_SP, REG_X},
    {OPC_X_A, REG_X, REG_A}, {OPC_X_SP, REG_X, REG_SP},
    {OPC_X_Y, REG_X, REG_Y}, {OPC_Y_A, REG_Y, REG_A},
    {OPC_Y_X, REG_Y, REG_X}};
  // Store table: prefix, opcode, source, cycles
  localparam logic [15:0] ST [7] = '{{1'b0, OPC_STA_DIR, REG_A, 4'h4},
    {1'b0, OPC_STA_DIRX, REG_A, 4'h5}, {1'b0, OPC_STX_DIR, REG_X, 4'h4},
    {1'b0, OPC_STX_DIRY, REG_X, 4'h5}, {1'b0, OPC_STY_DIR, REG_Y, 4'h4},
    {1'b0, OPC_STY_DIRX, REG_Y, 4'h5}, {1'b1, OPC_STA_DIR, REG_B, 4'h6}};
  subset_core dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
    .we_i(we), .adr_i(adr), .sel_i(4'hf), .dat_i(dat), .dat_o(dat_o),
    .ack_o(ack_o), .mem_rdata_i(mem_rdata), .mem_rd_o(mem_rd_o),
    .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .wake_i(wake), .osc_stop_o(osc_stop_o),
    .core_halt_o(core_halt_o));
  mem_model mem (.clk_i(clk_i), .mem_rd_i(mem_rd_o),
    .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata));
  initial forever #10 clk_i = ~clk_i;
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [40:0] s,
      input logic [40:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Classic cycle; a read notes its expectation for the watcher
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e = 0, input logic [31:0] m = 32'hffff_ffff);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    if (!w) rdq.push_back({e, m});
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      complete_run();
    end else begin
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  // Launch, let the fixed run elapse, then check the status word
  task automatic exe(input logic [23:0] ins, input logic [3:0] c,
      input logic [2:0] l, input logic [4:0] f = 0,
      input logic [31:0] m = 32'hffff_ffff);
    wb(1'b1, OFF_INSN, {8'h00, ins});
    repeat (12) @(posedge clk_i);
    wb(1'b0, OFF_STAT, 0, {16'h0, c, 1'b0, l, 3'b0, f}, m);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Watcher pairs each answer with the oldest note
  always @(posedge clk_i) begin
    note_type t;
    if (ack_o === 1'b1 && cyc && !we) begin
      t = rdq.pop_front();
      chk("read", dat_o & t.m, t.v & t.m);
    end
    if (mem_we_o === 1'b1) begin
      chk("mem", {mem_byte_o, mem_addr_o, mem_wdata_o},
        wrq.pop_front());
    end
  end
  initial begin
    logic [15:0] v, w;
    logic [23:0] e;
    logic [7:0] k;
    int s, d;
    v = $urandom(32'hbbdd);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 6; i++) wb(1'b0, 8'(OFF_REGS + 4 * i), 0, REG_RST);
    wb(1'b0, OFF_PS, 0, PS_RST);
    foreach (TT[i]) for (int p = 0; p < 2; p++) begin
      s = TT[i][5:3];
      d = TT[i][2:0];
      if (p == 0 || s == 0 || d == 0) begin
        if (p == 1) s = (s == 0) ? 1 : s;
        if (p == 1) d = (d == 0) ? 1 : d;
        v = $urandom;
        wb(1'b1, 8'(OFF_REGS + 4 * s), {16'h0, v});
        exe(p ? {8'h0, TT[i][13:6], OPC_PREFIX_B} : {16'h0, TT[i][13:6]},
          p ? 4'h4 : 4'h2, p ? LEN_2 : LEN_1);
        wb(1'b0, 8'(OFF_REGS + 4 * d), 0, {16'h0, v});
      end
    end
    v = $urandom;
    w = $urandom;
    wb(1'b1, OFF_REGS, {16'h0, v});
    wb(1'b1, 8'(OFF_REGS + 4), {16'h0, w});
    exe({8'h0, OPC_SWAP_TAIL, OPC_SWAP_LEAD}, CYC_SWAP, LEN_2);
    wb(1'b0, OFF_REGS, 0, {16'h0, w});
    wb(1'b0, 8'(OFF_REGS + 4), 0, {16'h0, v});
    foreach (ST[i]) begin
      v = $urandom;
      e = $urandom;
      wb(1'b1, OFF_EA, {8'h0, e});
      wb(1'b1, 8'(OFF_REGS + 4 * ST[i][6:4]), {16'h0, v});
      wrq.push_back({1'b0, e, v});
      exe(ST[i][15] ? {8'h0, ST[i][14:7], OPC_PREFIX_B} : {16'h0, ST[i][14:7]},
        ST[i][3:0], ST[i][15] ? LEN_3 : LEN_2);
    end
    e = $urandom;
    k = $urandom;
    wb(1'b1, OFF_EA, {8'h0, e});
    wrq.push_back({1'b0, e, (e[15:0] ^ 16'h5a5a) | {8'h0, k}});
    exe({k, 8'h0, OPC_SET_BIT}, CYC_SET_BIT, LEN_3);
    exe({16'h0, OPC_SET_C}, CYC_IMP, LEN_1);
    exe({8'h40, 8'h0, OPC_SET_PS}, CYC_SET_PS, LEN_2);
    exe({16'h0, OPC_SET_I}, CYC_IMP, LEN_1);
    wb(1'b0, OFF_PS, 0, 32'h0000_0045);
    exe({16'h0, OPC_SET_M}, CYC_IMP, LEN_1);
    wb(1'b0, OFF_PS, 0, 32'h0000_0065);
    // Narrow accumulator store must flag a byte access
    v = $urandom;
    e = $urandom;
    wb(1'b1, OFF_EA, {8'h0, e});
    wb(1'b1, OFF_REGS, {16'h0, v});
    wrq.push_back({1'b1, e, v});
    exe({16'h0, OPC_STA_DIR}, 4'h4, LEN_2);
    exe({16'h0, 8'h00}, 0, 0, 5'b01000, 32'h0000_001f);
    exe({16'h0, OPC_HALT_OSC}, CYC_HALT, LEN_1, 5'b00010);
    chk("osc stop", osc_stop_o, 1'b1);
    exe({16'h0, OPC_SET_C}, 0, 0, 5'b10010, 32'h0000_0016);
    wb(1'b1, OFF_WAKE, 32'h0000_0001);
    exe({16'h0, OPC_HALT_CLK}, CYC_HALT, LEN_1, 5'b00100);
    chk("core halt", {osc_stop_o, core_halt_o}, 2'b01);
    wake <= 1'b1;
    repeat (4) @(posedge clk_i);
    wake <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, OFF_STAT, 0, 0, 32'h0000_0006);
    repeat (4) @(posedge clk_i);
    complete_run();
  end
endmodule
